// ==== rtl/line_timing_pkg.sv ====
// Constants, field layouts and carriers for the line-sensor timing control block.
// Assumes a single 200 MHz clock; one internal state lasts one clock cycle.
package line_timing_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [6:0] OFS_FINE_DELAY_TAP_SET3   = 7'h4b;
  localparam logic [6:0] OFS_INV_DELAY_STATE_SET1  = 7'h4c;
  localparam logic [6:0] OFS_INV_DELAY_STATE_SET2  = 7'h4d;
  localparam logic [6:0] OFS_INV_DELAY_STATE_SET3  = 7'h4e;
  localparam logic [6:0] OFS_TIMING_GEN_CONTROL    = 7'h50;
  localparam logic [6:0] OFS_TIMING_GEN_MODE       = 7'h51;

  // ==========================================================================
  // Reset values and writable-bit masks
  localparam logic [15:0] REG_RESET        = 16'h0000;
  localparam logic [15:0] MASK_TAP_SET3    = 16'h83ff;
  localparam logic [15:0] MASK_INV_STATE   = 16'hfffe;
  localparam logic [15:0] MASK_TG_CONTROL  = 16'h0381;
  localparam logic [15:0] MASK_TG_MODE     = 16'hf347;

  // ==========================================================================
  // Field positions
  localparam int TAP_COMBINE_BIT      = 15;
  localparam int TAP_FIELD_MSB        = 9;
  localparam int STATE_SEL_MSB        = 15;
  localparam int STATE_SEL_LSB        = 10;
  localparam int INV_FIELD_MSB        = 9;
  localparam int INV_FIELD_LSB        = 1;
  localparam int EVEN_ONLY_BIT        = 9;
  localparam int CLOCK_FORCE_BIT      = 8;
  localparam int ADC_GEN_EN_BIT       = 7;
  localparam int CAPTURE_RUN_BIT      = 0;
  localparam int TRIG_WIDTH_MSB       = 15;
  localparam int TRIG_WIDTH_LSB       = 13;
  localparam int TRIG_INVERT_BIT      = 12;
  localparam int SYNC_RISE_SRC_BIT    = 9;
  localparam int SYNC_SRC_BIT         = 8;
  localparam int TRIG_INTERNAL_BIT    = 6;
  localparam int TRIG_CLEAR_MSB       = 2;

  // ==========================================================================
  // Serial frame and state counting
  localparam logic [4:0] ADDR_BITS      = 5'd8;
  localparam logic [4:0] FRAME_BITS     = 5'd24;
  localparam logic [2:0] STATES_LOW_RES = 3'd3;
  localparam logic [2:0] STATES_HI_RES  = 3'd6;
  localparam logic [3:0] PAGE_LAST      = 4'hc;
  localparam int         DELAY_SETS     = 3;

  typedef enum logic [1:0] {SER_IDLE, SER_ADDR, SER_DATA} ser_state_e;

  // Host serial pins, sampled on the core clock
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } host_pins_s;

  // Per-set delay selection towards the analog delay line
  typedef struct packed {
    logic       active;
    logic [8:0] inv_tap;
  } delay_set_s;

endpackage

// ==== rtl/delay_set_apply.sv ====
// One delay set: decides whether the set applies in the current state.
// Assumes the state index is in 0..5 and the fields come straight from registers.
`timescale 1ns/1ps
module delay_set_apply
  import line_timing_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  // Settings and current state
  input  wire logic [5:0] state_sel_in,
  input  wire logic [8:0] inv_tap_in,
  input  wire logic [2:0] state_idx_in,
  input  wire logic       enable_in,
  // Result
  output delay_set_s      set_out
);

  // One-hot state selection, zero selects nothing
  function automatic logic state_hit(input logic [5:0] sel, input logic [2:0] idx);
    state_hit = sel[idx];
  endfunction

  wire logic hit_now;
  assign hit_now = enable_in & state_hit(state_sel_in, state_idx_in);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      set_out <= '0;
    end else begin
      set_out.active  <= hit_now;
      set_out.inv_tap <= hit_now ? inv_tap_in : 9'h000;
    end
  end

endmodule

// ==== rtl/line_timing_ctrl.sv ====
// Timing-generator control: serial register port, state counter, AFE clocks,
// line trigger, trigger clear and line-sync event selection.
// Assumes host pins and event inputs are synchronous to core_clk_in.
// Function
// - Tap field 3 one-hot: 00 no clock, 01 undelayed, higher bits add tenths.
// - Bit 15 of tap set 3 picks OR (0) or AND (1) tap combining.
// - State selection is six-bit one-hot; 00 none, 01..20 states 0..5.
// - Inverted-tap field bits 9..1 one-hot; 00 none; bit 0 reserved.
// - Bits 15..10 of each inverted register choose that set's state.
// - Control bit 9 set: AFE clocks only in even cycles.
// - Control bit 8 set: AFE clocks ignore the timing window.
// - Control bit 7 enables internal ADC sample clock generation.
// - Control bit 0 starts image capture; clear means idle.
// - Trigger width field sets output pulse width in states.
// - Mode bit 12 inverts an external trigger input.
// - Mode bit 9 picks internal or external line-sync rising event.
// - Line-sync falling event always comes from internal patterns; with mode bit 8 set the output follows the external input instead.
// - Mode bit 8 chooses line-sync source; one means external input.
// - Mode bit 6 set: trigger generated internally; clear: external input.
// - Trigger clear delayed by clear field states after the trigger.
// - Page select 00..0C chooses which drive clock the taps address.
// - Resolution gives 3 or 6 states per ADC clock cycle.
`timescale 1ns/1ps
module line_timing_ctrl
  import line_timing_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  // Serial host port
  input  host_pins_s      host_in,
  output logic            sdo_out,
  output logic            sdo_oe_out,
  // Configuration from neighbouring blocks
  input  wire logic       pattern_resolution_in,
  input  wire logic [3:0] delay_page_sel_in,
  input  wire logic       afe_window_in,
  // Line events
  input  wire logic       line_start_in,
  input  wire logic       line_trigger_in,
  input  wire logic       sync_rise_int_in,
  input  wire logic       sync_fall_int_in,
  input  wire logic       sync_rise_ext_in,
  input  wire logic       line_sync_ext_in,
  // AFE clocks
  output logic            adc_sample_clock_out,
  output logic            sampling_clock_a_out,
  output logic            sampling_clock_b_out,
  // Trigger and line sync
  output logic            line_trigger_out,
  output logic            line_trigger_oe_out,
  output logic            trigger_clear_out,
  output logic            line_sync_out,
  output logic            capture_run_out,
  // Fine delay towards the delay line
  output logic [3:0]      delay_page_out,
  output logic [9:0]      delay_tap_field3_out,
  output logic            tap_combine_sel3_out,
  output logic            sensor_drive_clock_en_out,
  output delay_set_s      delay_set_out [DELAY_SETS]
);

  // ==========================================================================
  // Registers
  logic [15:0] tap_set3_r, inv_set_r [DELAY_SETS], tg_control_r, tg_mode_r;
  ser_state_e  ser_state_r;
  logic [4:0]  bit_cnt_r;
  logic [15:0] shift_in_r, shift_out_r;
  logic [6:0]  addr_r;
  logic        rd_r, sclk_q_r;

  wire logic sclk_rise, frame_off, addr_done, write_done;
  assign sclk_rise  = host_in.sclk & ~sclk_q_r;
  assign frame_off  = host_in.cs_n;
  assign addr_done  = sclk_rise & (ser_state_r == SER_ADDR) & (bit_cnt_r == ADDR_BITS - 5'd1);
  assign write_done = sclk_rise & (ser_state_r == SER_DATA) & (bit_cnt_r == FRAME_BITS - 5'd1)
                      & ~rd_r;

  wire logic [6:0] addr_now;
  assign addr_now = {shift_in_r[5:0], host_in.sdi};

  // Read mux; unmapped offsets read zero
  function automatic logic [15:0] reg_read(input logic [6:0] a);
    unique case (a)
      OFS_FINE_DELAY_TAP_SET3:  reg_read = tap_set3_r;
      OFS_INV_DELAY_STATE_SET1: reg_read = inv_set_r[0];
      OFS_INV_DELAY_STATE_SET2: reg_read = inv_set_r[1];
      OFS_INV_DELAY_STATE_SET3: reg_read = inv_set_r[2];
      OFS_TIMING_GEN_CONTROL:   reg_read = tg_control_r;
      OFS_TIMING_GEN_MODE:      reg_read = tg_mode_r;
      default:                  reg_read = 16'h0000;
    endcase
  endfunction

  wire logic [15:0] wr_data, rd_word;
  assign wr_data = {shift_in_r[14:0], host_in.sdi};
  assign rd_word = reg_read(addr_now);

  // ==========================================================================
  // Serial frame: 1 read flag, 7 address bits, 16 data bits, MSB first
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ser_state_r <= SER_IDLE;
      bit_cnt_r   <= '0;
      shift_in_r  <= '0;
      shift_out_r <= '0;
      addr_r      <= '0;
      rd_r        <= 1'b0;
      sclk_q_r    <= 1'b0;
      sdo_out     <= 1'b0;
      sdo_oe_out  <= 1'b0;
    end else begin
      sclk_q_r <= host_in.sclk;
      if (frame_off) begin
        ser_state_r <= SER_IDLE;
        bit_cnt_r   <= '0;
        sdo_oe_out  <= 1'b0;
      end else begin
        unique case (ser_state_r)
          SER_IDLE: begin
            ser_state_r <= SER_ADDR;
          end
          SER_ADDR: begin
            if (sclk_rise) begin
              shift_in_r <= wr_data;
              bit_cnt_r  <= bit_cnt_r + 5'd1;
              if (bit_cnt_r == 5'd0) begin
                rd_r <= host_in.sdi;
              end
              if (addr_done) begin
                addr_r      <= addr_now;
                ser_state_r <= SER_DATA;
                shift_out_r <= {rd_word[14:0], 1'b0};
                sdo_out     <= rd_word[15];
                sdo_oe_out  <= rd_r;
              end
            end
          end
          SER_DATA: begin
            if (sclk_rise) begin
              shift_in_r  <= wr_data;
              shift_out_r <= {shift_out_r[14:0], 1'b0};
              sdo_out     <= shift_out_r[15];
              bit_cnt_r   <= (bit_cnt_r == FRAME_BITS - 5'd1) ? 5'd0 : bit_cnt_r + 5'd1;
              if (bit_cnt_r == FRAME_BITS - 5'd1) begin
                ser_state_r <= SER_IDLE;
                sdo_oe_out  <= 1'b0;
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Register writes; reserved bits are masked off
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tap_set3_r   <= REG_RESET;
      inv_set_r    <= '{default: REG_RESET};
      tg_control_r <= REG_RESET;
      tg_mode_r    <= REG_RESET;
    end else if (write_done) begin
      unique case (addr_r)
        OFS_FINE_DELAY_TAP_SET3:  tap_set3_r   <= wr_data & MASK_TAP_SET3;
        OFS_INV_DELAY_STATE_SET1: inv_set_r[0] <= wr_data & MASK_INV_STATE;
        OFS_INV_DELAY_STATE_SET2: inv_set_r[1] <= wr_data & MASK_INV_STATE;
        OFS_INV_DELAY_STATE_SET3: inv_set_r[2] <= wr_data & MASK_INV_STATE;
        OFS_TIMING_GEN_CONTROL:   tg_control_r <= wr_data & MASK_TG_CONTROL;
        OFS_TIMING_GEN_MODE:      tg_mode_r    <= wr_data & MASK_TG_MODE;
        default:                  ;
      endcase
    end
  end

  // ==========================================================================
  // Internal state counter, 3 or 6 states per ADC cycle
  logic [2:0] state_idx_r;
  logic       odd_cycle_r;
  wire logic  run, state_last;
  wire logic [2:0] state_count;
  assign run         = tg_control_r[CAPTURE_RUN_BIT];
  assign state_count = pattern_resolution_in ? STATES_HI_RES : STATES_LOW_RES;
  assign state_last  = (state_idx_r == state_count - 3'd1);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_idx_r <= '0;
      odd_cycle_r <= 1'b0;
    end else if (!run || trigger_clear_out) begin
      state_idx_r <= '0;
      odd_cycle_r <= 1'b0;
    end else begin
      state_idx_r <= state_last ? 3'd0 : state_idx_r + 3'd1;
      odd_cycle_r <= odd_cycle_r ^ state_last;
    end
  end

  // ==========================================================================
  // AFE clocks
  wire logic afe_gate, adc_phase_hi;
  assign afe_gate = run & tg_control_r[ADC_GEN_EN_BIT]
                    & (tg_control_r[CLOCK_FORCE_BIT] | afe_window_in)
                    & ~(tg_control_r[EVEN_ONLY_BIT] & odd_cycle_r);
  assign adc_phase_hi = (state_idx_r < (state_count >> 1));

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      adc_sample_clock_out <= 1'b0;
      sampling_clock_a_out <= 1'b0;
      sampling_clock_b_out <= 1'b0;
    end else begin
      adc_sample_clock_out <= afe_gate & adc_phase_hi;
      sampling_clock_a_out <= afe_gate & (state_idx_r == 3'd0);
      sampling_clock_b_out <= afe_gate & state_last;
    end
  end

  // ==========================================================================
  // Line trigger, its width and the delayed clear
  logic       ext_trig_q_r;
  logic [2:0] width_cnt_r, clear_cnt_r;
  logic       clear_pend_r;
  wire logic  trig_internal, ext_level, trig_event;
  wire logic [2:0] width_code, width_states, clear_code;
  assign trig_internal = tg_mode_r[TRIG_INTERNAL_BIT];
  assign ext_level     = line_trigger_in ^ tg_mode_r[TRIG_INVERT_BIT];
  assign trig_event    = run & (trig_internal ? line_start_in : (ext_level & ~ext_trig_q_r));
  assign width_code    = tg_mode_r[TRIG_WIDTH_MSB:TRIG_WIDTH_LSB];
  assign width_states  = (width_code == 3'd0) ? 3'd1 : width_code;
  assign clear_code    = tg_mode_r[TRIG_CLEAR_MSB:0];

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_trig_q_r        <= 1'b0;
      width_cnt_r         <= '0;
      line_trigger_out    <= 1'b0;
      line_trigger_oe_out <= 1'b0;
    end else begin
      ext_trig_q_r        <= ext_level;
      line_trigger_oe_out <= trig_internal;
      if (trig_internal && trig_event) begin
        width_cnt_r      <= width_states - 3'd1;
        line_trigger_out <= 1'b1;
      end else if (width_cnt_r != 3'd0) begin
        width_cnt_r <= width_cnt_r - 3'd1;
      end else begin
        line_trigger_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clear_cnt_r       <= '0;
      clear_pend_r      <= 1'b0;
      trigger_clear_out <= 1'b0;
    end else begin
      trigger_clear_out <= 1'b0;
      if (trig_event) begin
        clear_cnt_r       <= clear_code;
        clear_pend_r      <= (clear_code != 3'd0);
        trigger_clear_out <= (clear_code == 3'd0);
      end else if (clear_pend_r) begin
        clear_cnt_r <= clear_cnt_r - 3'd1;
        if (clear_cnt_r == 3'd1) begin
          clear_pend_r      <= 1'b0;
          trigger_clear_out <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Line sync
  wire logic rise_event, sync_external;
  assign sync_external = tg_mode_r[SYNC_SRC_BIT];
  assign rise_event    = tg_mode_r[SYNC_RISE_SRC_BIT] ? sync_rise_ext_in : sync_rise_int_in;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      line_sync_out <= 1'b0;
    end else if (sync_external) begin
      line_sync_out <= line_sync_ext_in;
    end else if (sync_fall_int_in) begin
      line_sync_out <= 1'b0;
    end else if (rise_event) begin
      line_sync_out <= 1'b1;
    end
  end

  // ==========================================================================
  // Fine delay selection
  wire logic page_valid;
  assign page_valid = (delay_page_sel_in <= PAGE_LAST);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      capture_run_out           <= 1'b0;
      delay_page_out            <= '0;
      delay_tap_field3_out      <= '0;
      tap_combine_sel3_out      <= 1'b0;
      sensor_drive_clock_en_out <= 1'b0;
    end else begin
      capture_run_out           <= run;
      delay_page_out            <= page_valid ? delay_page_sel_in : delay_page_out;
      delay_tap_field3_out      <= tap_set3_r[TAP_FIELD_MSB:0];
      tap_combine_sel3_out      <= tap_set3_r[TAP_COMBINE_BIT];
      sensor_drive_clock_en_out <= |tap_set3_r[TAP_FIELD_MSB:0];
    end
  end

  for (genvar g = 0; g < DELAY_SETS; g++) begin : g_set
    delay_set_apply u_set (
      .core_clk_in  (core_clk_in),
      .nrst_in      (nrst_in),
      .state_sel_in (inv_set_r[g][STATE_SEL_MSB:STATE_SEL_LSB]),
      .inv_tap_in   (inv_set_r[g][INV_FIELD_MSB:INV_FIELD_LSB]),
      .state_idx_in (state_idx_r),
      .enable_in    (run & page_valid),
      .set_out      (delay_set_out[g])
    );
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_tap_clock_en: assert property (
    ##1 sensor_drive_clock_en_out == $past(|tap_set3_r[TAP_FIELD_MSB:0]))
    else $error("drive clock enable does not follow tap field");
  chk_combine_mode: assert property (
    $changed(tap_set3_r[TAP_COMBINE_BIT])
    |=> tap_combine_sel3_out == $past(tap_set3_r[TAP_COMBINE_BIT]))
    else $error("combine select not taken from bit 15");
  chk_state_range: assert property (state_idx_r < state_count)
    else $error("state index beyond resolution");
  chk_state_select: assert property (
    run && page_valid && inv_set_r[0][STATE_SEL_LSB + 32'(state_idx_r)]
    |=> delay_set_out[0].active)
    else $error("selected state did not activate delay set");
  chk_even_only: assert property (
    tg_control_r[EVEN_ONLY_BIT] && odd_cycle_r |=> !adc_sample_clock_out)
    else $error("ADC clock in odd cycle");
  chk_adc_disabled: assert property (
    !tg_control_r[ADC_GEN_EN_BIT] |=> !adc_sample_clock_out && !sampling_clock_a_out)
    else $error("AFE clock while generation disabled");
  chk_window_gate: assert property (
    !tg_control_r[CLOCK_FORCE_BIT] && !afe_window_in |=> !sampling_clock_b_out)
    else $error("AFE clock outside window");
  chk_trig_width: assert property (
    trig_internal && trig_event && width_code == 3'd5
    |=> line_trigger_out [*5] ##1 !line_trigger_out)
    else $error("trigger width wrong");
  chk_clear_delay: assert property (
    trig_event && clear_code == 3'd2 && run
    |=> !trigger_clear_out ##1 !trigger_clear_out ##1 trigger_clear_out)
    else $error("trigger clear delay wrong");
  chk_sync_fall: assert property (
    !sync_external && sync_fall_int_in |=> !line_sync_out)
    else $error("line sync did not fall on internal event");

  cov_reg_write: cover property (write_done);
  cov_internal_trig: cover property (trig_internal && trig_event);
  cov_ext_sync: cover property (tg_mode_r[SYNC_RISE_SRC_BIT] && sync_rise_ext_in);
  cov_read_frame: cover property (addr_done && rd_r);

endmodule

// ==== bench/host_serial_model.sv ====
// Host side of the serial register port, stepping on the core clock.
// Assumes the device samples sclk on core_clk_in and answers one cycle late.
`timescale 1ns/1ps
module host_serial_model
  import line_timing_pkg::*;
(
  // Clock and pins
  input  wire logic core_clk_in,
  output host_pins_s host_out,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in
);
  initial host_out = 3'b100;
  // ======
  // Frame task
  // Clock never stops here, so no access meets a stopped PLL
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd,
                      output logic [15:0] q);
    logic [23:0] f;
    f = {rd, a, wd};
    q = 16'h0000;
    @(posedge core_clk_in) host_out.cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge core_clk_in) host_out.sdi <= f[i];
      repeat (2) @(posedge core_clk_in);
      host_out.sclk <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      if (i >= 1 && i <= 16) q[i-1] = sdo_oe_in ? sdo_in : 1'bx;
      host_out.sclk <= 1'b0;
    end
    @(posedge core_clk_in) host_out.cs_n <= 1'b1;
    host_out.sdi <= ~host_out.sdi;
  endtask
endmodule

// ==== bench/line_sensor_clock_timing_ctrl_bench.sv ====
// Bench: registers, trigger, line sync, AFE clocks and delay sets.
// Assumes the host model owns the serial pins.
`timescale 1ns/1ps
module line_sensor_clock_timing_ctrl_bench;
  import line_timing_pkg::*;
  logic       clk = 1'b0, nrst = 1'b0, res = 1'b0, win = 1'b0, lstart = 1'b0;
  logic       trig = 1'b0, rint = 1'b0, fint = 1'b0, rext = 1'b0, sext = 1'b0;
  logic [3:0] page = 4'h0;
  logic       sdo, sdo_oe, adc, cka, ckb, trg, trg_oe, clr, sync, run, comb, dce;
  logic [3:0] pg;
  logic [9:0] tap;
  host_pins_s hp;
  delay_set_s dset [DELAY_SETS];
  int         miscompares = 0, comparisons = 0, cyc = 0;
  always #2.5 clk = ~clk;
  host_serial_model i_host (.core_clk_in(clk), .host_out(hp), .sdo_in(sdo), .sdo_oe_in(sdo_oe));
  line_timing_ctrl i_dut (
    .core_clk_in(clk), .nrst_in(nrst), .host_in(hp), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .pattern_resolution_in(res), .delay_page_sel_in(page), .afe_window_in(win),
    .line_start_in(lstart), .line_trigger_in(trig), .sync_rise_int_in(rint),
    .sync_fall_int_in(fint), .sync_rise_ext_in(rext), .line_sync_ext_in(sext),
    .adc_sample_clock_out(adc), .sampling_clock_a_out(cka), .sampling_clock_b_out(ckb),
    .line_trigger_out(trg), .line_trigger_oe_out(trg_oe), .trigger_clear_out(clr),
    .line_sync_out(sync), .capture_run_out(run), .delay_page_out(pg),
    .delay_tap_field3_out(tap), .tap_combine_sel3_out(comb),
    .sensor_drive_clock_en_out(dce), .delay_set_out(dset));
  // ======
  // Helpers
  task automatic test_done;
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] x;
    i_host.xfer(1'b0, a, d, x);
    step(3);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] x;
    i_host.xfer(1'b1, a, 16'h0000, x);
    chk(x, e);
  endtask
  task automatic pulse(input int w);
    {fint, rext, rint} <= 3'(1 << w);
    step(1);
    {fint, rext, rint} <= 3'h0;
    step(4);
  endtask
  task automatic watch(output int n, output int t0, output int tc);
    n = 0;
    t0 = -1;
    tc = -1;
    for (int c = 0; c < 16; c++) begin
      step(1);
      if (trg === 1'b1 && t0 < 0) t0 = c;
      if (trg === 1'b1) n++;
      if (clr === 1'b1 && tc < 0) tc = c;
    end
  endtask
  // ======
  // Scenarios
  task automatic t_regs;
    logic [6:0]  o [7];
    logic [15:0] m [7];
    o = '{7'h4b, 7'h4c, 7'h4d, 7'h4e, 7'h50, 7'h51, 7'h4f};
    m = '{16'h83ff, 16'hfffe, 16'hfffe, 16'hfffe, 16'h0381, 16'hf347, 16'h0000};
    for (int i = 0; i < 7; i++) begin
      rd(o[i], 16'h0000);
      wr(o[i], 16'hffff);
      rd(o[i], m[i]);
      wr(o[i], 16'h0000);
    end
  endtask
  task automatic t_tap;
    wr(7'h4b, 16'h8200);
    chk({comb, 5'h00, tap}, 16'h8200);
    chk(16'(dce), 16'h0001);
    wr(7'h4b, 16'h0000);
    chk(16'(dce), 16'h0000);
  endtask
  task automatic t_trig;
    int n, t0, tc;
    wr(7'h50, 16'h0001);
    for (int w = 0; w < 6; w++) begin
      wr(7'h51, 16'(w << 13) | 16'h0040 | 16'(w));
      chk(16'(trg_oe), 16'h0001);
      lstart <= 1'b1;
      step(1);
      lstart <= 1'b0;
      watch(n, t0, tc);
      chk(16'(n), 16'(w > 0 ? w : 1));
      chk(16'(tc - t0), 16'(w));
    end
    trig <= 1'b1;
    wr(7'h51, 16'h1000);
    chk(16'(trg_oe), 16'h0000);
    watch(n, t0, tc);
    chk(16'(n), 16'h0000);
    chk(16'(tc), 16'hffff);
    trig <= 1'b0;
    watch(n, t0, tc);
    chk(16'(n), 16'h0000);
    chk(16'(tc), 16'h0001);
  endtask
  task automatic t_sync;
    wr(7'h51, 16'h0100);
    sext <= 1'b1;
    step(4);
    chk(16'(sync), 16'h0001);
    sext <= 1'b0;
    step(4);
    chk(16'(sync), 16'h0000);
    wr(7'h51, 16'h0200);
    pulse(0);
    chk(16'(sync), 16'h0000);
    pulse(1);
    chk(16'(sync), 16'h0001);
    pulse(2);
    chk(16'(sync), 16'h0000);
  endtask
  task automatic t_afe;
    int n [4];
    logic [15:0] cv [4];
    cv = '{16'h0081, 16'h0181, 16'h0381, 16'h0101};
    for (int k = 0; k < 4; k++) begin
      wr(7'h50, cv[k]);
      n[k] = 0;
      for (int c = 0; c < 24; c++) begin
        step(1);
        n[k] += adc + cka + ckb;
      end
    end
    chk(16'(run), 16'h0001);
    chk(16'(n[0]), 16'h0000);
    chk(16'(n[1] > 0), 16'h0001);
    chk(16'(n[2] > 0 && n[2] < n[1]), 16'h0001);
    chk(16'(n[3]), 16'h0000);
  endtask
  task automatic t_dset;
    int n, n1, n2;
    int ex [3];
    logic [15:0] iv [3];
    logic [8:0]  itap;
    ex = '{4, 0, 2};
    iv = '{16'h0402, 16'h8002, 16'h8002};
    itap = 9'h000;
    for (int k = 0; k < 3; k++) begin
      res <= (k == 2);
      wr(7'h4c, iv[k]);
      n = 0;
      for (int c = 0; c < 12; c++) begin
        step(1);
        n += dset[0].active;
        if (dset[0].active === 1'b1) itap = dset[0].inv_tap;
      end
      chk(16'(n), 16'(ex[k]));
    end
    chk({7'h00, itap}, 16'h0001);
    wr(7'h4e, 16'h0402);
    n1 = 0;
    n2 = 0;
    for (int c = 0; c < 12; c++) begin
      step(1);
      n1 += dset[1].active;
      n2 += dset[2].active;
    end
    chk(16'(n1), 16'h0000);
    chk(16'(n2), 16'h0002);
    page <= 4'h5;
    step(3);
    chk(16'(pg), 16'h0005);
    page <= 4'hd;
    step(3);
    chk(16'(pg), 16'h0005);
    wr(7'h50, 16'h0000);
    chk(16'(run), 16'h0000);
  endtask
  initial begin
    step(20);
    nrst <= 1'b1;
    step(2);
    t_regs();
    t_tap();
    t_trig();
    t_sync();
    t_afe();
    t_dset();
    test_done();
  end
endmodule
